// ### sim/frb_core_model.sv
// Purpose: Behavioural storage core facing the register bank.
// Assumes: Busy for a fixed time after reset and after each command.
// Notes:   Capacity halves per file size step; levels come from the bench.
`timescale 1ns/1ps
module frb_core_model
#(
    parameter int unsigned INIT_CYC = 20,
    parameter int unsigned OP_CYC   = 30
)
(
    input  wire logic                   mclk,
    input  wire logic                   resetn,
    input  wire frb_pkg::frb_core_out_s core_out,
    input  wire logic                   err_req,
    input  wire frb_pkg::frb_speed_e    speed,
    input  wire logic [31:0]            err_vec,
    input  wire logic [63:0]            dbg,
    output frb_pkg::frb_core_in_s       core_in
);
    import frb_pkg::*;
    int unsigned cnt_q;
    // Counts down the initialisation and each requested operation.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            cnt_q <= INIT_CYC;
        else if (core_out.command_request_pulse)
            cnt_q <= OP_CYC;
        else if (cnt_q != 0)
            cnt_q <= cnt_q - 1;
    end
    // Presents the core levels to the bank.
    always_comb
    begin
        core_in.busy               = (cnt_q != 0);
        core_in.error              = err_req;
        core_in.speed              = speed;
        core_in.max_file_count     = 16'h1000 >> core_out.file_size_select;
        core_in.error_cause_vector = err_vec;
        core_in.core_debug_bus     = dbg;
    end
endmodule : frb_core_model

// ### sim/frb_properties.sv
// Purpose: Port assertions for the file core register bank.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound to the bank from the test top.
`timescale 1ns/1ps
module frb_properties
#(
    parameter int unsigned BYTE_CNT_W = 40
)
(
    input wire logic                   mclk,
    input wire logic                   resetn,
    input wire frb_pkg::frb_bus_req_s  bus_req,
    input wire logic [31:0]            reg_rdata,
    input wire logic                   reg_rvalid,
    input wire frb_pkg::frb_core_in_s  core_in,
    input wire frb_pkg::frb_core_out_s core_out,
    input wire logic                   check_mismatch,
    input wire frb_pkg::frb_fail_s     check_info,
    input wire logic [BYTE_CNT_W-1:0]  byte_count
);
    import frb_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence s_rd(logic [11:0] a);
        bus_req.rd && bus_req.addr == a;
    endsequence
    sequence s_cmd;
        bus_req.wr && bus_req.addr == FRB_OFS_CMD;
    endsequence
    sequence s_fail;
        check_mismatch && !core_out.test_reset ##1 !(bus_req.wr && bus_req.addr == FRB_OFS_CMD)
            && !core_out.test_reset ##1 s_rd(FRB_OFS_STATUS);
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_read_answer: assert property (bus_req.rd |=>
        reg_rvalid ##1 (!reg_rvalid || $past(bus_req.rd))) else $error("read without single answer");
    a_status_levels: assert property (s_rd(FRB_OFS_STATUS) |=>
        reg_rdata[1:0] == $past({core_in.error, core_in.busy})) else $error("status busy or error wrong");
    a_status_speed: assert property (s_rd(FRB_OFS_STATUS) |=>
        reg_rdata[4:3] == $past(core_in.speed)) else $error("status speed wrong");
    a_cap_read: assert property (s_rd(FRB_OFS_CAP) |=>
        reg_rdata == {16'h0000, $past(core_in.max_file_count)}) else $error("capacity read wrong");
    a_err_read: assert property (s_rd(FRB_OFS_ERR) |=>
        reg_rdata == $past(core_in.error_cause_vector)) else $error("error cause read wrong");
    a_dbg_high: assert property (s_rd(FRB_OFS_DBGH) |=>
        reg_rdata == $past(core_in.core_debug_bus[63:32])) else $error("debug high read wrong");
    a_cmd_pulse: assert property (s_cmd |=> core_out.command_request_pulse
        && core_out.command_code == $past(bus_req.wdata[1:0])) else $error("command not issued");
    a_pulse_cause: assert property (core_out.command_request_pulse |-> $past(bus_req.wr)
        && $past(bus_req.addr) == FRB_OFS_CMD) else $error("stray command pulse");
    a_fail_flag: assert property (s_fail |=> reg_rdata[2])
        else $error("fail flag missing");
    a_ro_ignored: assert property (bus_req.wr && bus_req.addr >= FRB_OFS_STATUS |=>
        !core_out.command_request_pulse && $stable(core_out.file_size_select)) else $error("read-only write acted");
    a_high_frozen: assert property (s_rd(FRB_OFS_BCL) ##1 !bus_req.rd ##1 s_rd(FRB_OFS_BCH) |=>
        reg_rdata == {24'h000000, $past(byte_count[39:32], 3)}) else $error("byte count high wrong");
    a_reset_size: assert property ($rose(resetn) |-> core_out.file_size_select == FRB_FSIZE_RST)
        else $error("file size not default");
    a_size_write: assert property (bus_req.wr && bus_req.addr == FRB_OFS_FSIZE |=>
        core_out.file_size_select == $past(bus_req.wdata[2:0])) else $error("file size not taken");
    a_low_count: assert property (s_rd(FRB_OFS_BCL) |=>
        reg_rdata == $past(byte_count[31:0])) else $error("byte count low wrong");
endmodule : frb_properties

// ### sim/test_file_core_user_register_bank.sv
// Purpose: Self-checking bench of the file core register bank.
// Assumes: Reads answer one cycle after the strobe.
// Notes:   Expected reads are queued and checked by a monitor.
`timescale 1ns/1ps
module test_file_core_user_register_bank;
    import frb_pkg::*;
    logic           mclk;
    logic           resetn;
    frb_bus_req_s   bus_req;
    logic [31:0]    reg_rdata;
    logic           reg_rvalid;
    frb_core_in_s   core_in;
    frb_core_out_s  core_out;
    logic           check_mismatch;
    frb_fail_s      check_info;
    frb_fail_s      fi;
    logic [1:0]     cmd;
    logic [15:0]    fname;
    logic [31:0]    stamp;
    logic [39:0]    byte_count;
    logic           err_req;
    frb_speed_e     speed;
    logic [31:0]    err_vec;
    logic [63:0]    dbg;
    logic [31:0]    exp_q[$];
    int             error_cnt;
    int             tests_run;
    int             cyc;
    frb_regbank #(.BYTE_CNT_W(40)) DUT (.mclk(mclk), .resetn(resetn), .bus_req(bus_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .core_in(core_in), .core_out(core_out), .check_mismatch(check_mismatch),
        .check_info(check_info), .byte_count(byte_count));
    frb_core_model MODEL (.mclk(mclk), .resetn(resetn), .core_out(core_out), .err_req(err_req), .speed(speed),
        .err_vec(err_vec), .dbg(dbg), .core_in(core_in));
    // Free-running 250 MHz clock.
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Compares a registered core-side output with its expected level.
    task automatic check_core(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: core output %h expected %h", $time, got, exp);
        end
    endtask : check_core
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        #1 bus_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge mclk);
        #1 bus_req.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge mclk);
        #1 exp_q.push_back(e);
        bus_req.addr = a;
        bus_req.rd   = 1'b1;
        @(posedge mclk);
        #1 bus_req.rd = 1'b0;
    endtask : rd
    task automatic wait_idle;
        int n;
        n = 0;
        while (core_in.busy !== 1'b0 && n < 200)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= 200)
            check(32'h1, 32'h0);
    endtask : wait_idle
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    // Compares each answered read with the oldest queued expectation.
    always @(negedge mclk)
    begin
        if (reg_rvalid === 1'b1)
        begin
            if (exp_q.size() > 0)
                check(reg_rdata, exp_q.pop_front());
            else
                check(32'h1, 32'h0);
        end
    end
    // Cuts a hung run short.
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            complete_run();
        end
    end
    // Main sequence.
    initial
    begin
        {bus_req, check_mismatch, check_info, byte_count, err_req, err_vec, dbg} = '0;
        speed  = FRB_SPD_NONE;
        resetn = 1'b0;
        void'($urandom(79));
        repeat (10) @(posedge mclk);
        #1 resetn = 1'b1;
        wait_idle();
        check_core(32'(core_out.file_size_select), 32'h0);
        rd(FRB_OFS_CAP, 32'h1000);
        $display("test init done");
        for (int s = 0; s < 4; s++)
        begin
            speed   = frb_speed_e'(s[1:0]);
            err_req = s[0];
            rd(FRB_OFS_STATUS, {27'h0, s[1:0], 1'b0, s[0], 1'b0});
        end
        speed      = FRB_SPD_NONE;
        err_req    = 1'b0;
        err_vec    = $urandom;
        dbg        = {$urandom, $urandom};
        byte_count = {8'($urandom), 32'($urandom)};
        rd(FRB_OFS_ERR, err_vec);
        rd(FRB_OFS_DBGL, dbg[31:0]);
        rd(FRB_OFS_DBGH, dbg[63:32]);
        rd(FRB_OFS_BCL, byte_count[31:0]);
        // The high byte moves after the low read; the frozen byte must come back.
        byte_count[39:32] = ~byte_count[39:32];
        rd(FRB_OFS_BCH, {24'h0, ~byte_count[39:32]});
        wr(FRB_OFS_CAP, $urandom);
        wr(FRB_OFS_STATUS, 32'h1f);
        rd(FRB_OFS_CAP, 32'h1000);
        rd(FRB_OFS_STATUS, 32'h0);
        rd(12'h1c0, 32'h0);
        $display("test read-back done");
        for (int p = 0; p < 5; p++)
        begin
            wr(FRB_OFS_PATT, 32'(p));
            check_core(32'(core_out.pattern_select), 32'(p));
        end
        for (int i = 0; i < 3; i++)
        begin
            cmd   = (i == 0) ? 2'h0 : 2'(i + 1);
            fname = 16'($urandom);
            stamp = $urandom;
            wr(FRB_OFS_FNAME, {16'h0, fname});
            wr(FRB_OFS_FLEN, 32'(i + 1));
            wr(FRB_OFS_PATT, 32'h4);
            wr(FRB_OFS_FTIME, stamp);
            check_core({16'h0, core_out.first_file_name}, {16'h0, fname});
            check_core({16'h0, core_out.file_count}, 32'(i + 1));
            check_core(core_out.creation_timestamp, stamp);
            wr(FRB_OFS_CMD, {30'h0, cmd});
            check_core(32'(core_out.command_request_pulse), 32'h1);
            check_core(32'(core_out.command_code), {30'h0, cmd});
            rd(FRB_OFS_STATUS, 32'h1);
            check_core(32'(core_out.command_request_pulse), 32'h0);
            wait_idle();
        end
        $display("test commands done");
        wr(FRB_OFS_CMD, 32'h3);
        fi = {$urandom, 16'($urandom), $urandom, $urandom};
        check_info     = fi;
        check_mismatch = 1'b1;
        @(posedge mclk);
        #1 check_info = ~fi;
        @(posedge mclk);
        #1 check_mismatch = 1'b0;
        rd(FRB_OFS_STATUS, 32'h5);
        rd(FRB_OFS_FPOS, fi.position);
        rd(FRB_OFS_FID, {16'h0, fi.file_id});
        rd(FRB_OFS_EXP, fi.expected);
        rd(FRB_OFS_OBS, fi.observed);
        wait_idle();
        rd(FRB_OFS_STATUS, 32'h4);
        wr(FRB_OFS_TRST, 32'h1);
        check_core(32'(core_out.test_reset), 32'h1);
        rd(FRB_OFS_STATUS, 32'h0);
        wr(FRB_OFS_TRST, 32'h0);
        check_core(32'(core_out.test_reset), 32'h0);
        $display("test failure capture done");
        wr(FRB_OFS_FSIZE, 32'h3);
        check_core(32'(core_out.file_size_select), 32'h3);
        rd(FRB_OFS_CAP, 32'h200);
        wr(FRB_OFS_CMD, 32'h0);
        rd(FRB_OFS_STATUS, 32'h1);
        wait_idle();
        $display("test file size done");
        repeat (3) @(posedge mclk);
        if (exp_q.size() != 0)
            check(32'(exp_q.size()), 32'h0);
        complete_run();
    end
endmodule : test_file_core_user_register_bank
bind frb_regbank frb_properties #(.BYTE_CNT_W(BYTE_CNT_W)) u_props (.mclk(mclk), .resetn(resetn),
    .bus_req(bus_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .core_in(core_in), .core_out(core_out),
    .check_mismatch(check_mismatch), .check_info(check_info), .byte_count(byte_count));

// ### verilog/frb_capture.sv
// Purpose: Holds the first data-verify failure until the next test starts.
// Assumes: Checker reports a mismatch with a one-cycle valid and its details.
// Notes:   A mismatch in the clear cycle is kept; the set wins.
`timescale 1ns/1ps
module frb_capture
    import frb_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                resetn,
    input  wire logic                clear,
    input  wire logic                mismatch,
    input  wire frb_pkg::frb_fail_s  mismatch_info,
    output logic                     failed,
    output frb_pkg::frb_fail_s       held_info
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic      failed;
        frb_fail_s info;
    } frb_cap_state_s;

    frb_cap_state_s st_q;
    frb_cap_state_s st_d;

    // A mismatch is latched once; later ones do not overwrite the first.
    always_comb
    begin
        st_d = st_q;
        if (clear)
        begin
            st_d.failed = 1'b0;
        end
        if (mismatch && (!st_q.failed || clear))
        begin
            st_d.failed = 1'b1;
            st_d.info   = mismatch_info;
        end
    end

    // State register.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign failed    = st_q.failed;
    assign held_info = st_q.info;

endmodule : frb_capture

// ### verilog/frb_pkg.sv
// Purpose: Shared constants, types and carriers of the file core register bank.
// Assumes: Byte addresses on a 32-bit word register port.
// Notes:   All offsets are byte addresses of aligned words.
package frb_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam int unsigned FRB_AW = 12;
    localparam logic [11:0] FRB_OFS_FNAME  = 12'h000;
    localparam logic [11:0] FRB_OFS_FLEN   = 12'h004;
    localparam logic [11:0] FRB_OFS_FSIZE  = 12'h008;
    localparam logic [11:0] FRB_OFS_FTIME  = 12'h00c;
    localparam logic [11:0] FRB_OFS_CMD    = 12'h010;
    localparam logic [11:0] FRB_OFS_PATT   = 12'h014;
    localparam logic [11:0] FRB_OFS_TRST   = 12'h01c;
    localparam logic [11:0] FRB_OFS_STATUS = 12'h100;
    localparam logic [11:0] FRB_OFS_CAP    = 12'h104;
    localparam logic [11:0] FRB_OFS_ERR    = 12'h108;
    localparam logic [11:0] FRB_OFS_DBGL   = 12'h10c;
    localparam logic [11:0] FRB_OFS_DBGH   = 12'h110;
    localparam logic [11:0] FRB_OFS_FPOS   = 12'h180;
    localparam logic [11:0] FRB_OFS_FID    = 12'h184;
    localparam logic [11:0] FRB_OFS_EXP    = 12'h190;
    localparam logic [11:0] FRB_OFS_OBS    = 12'h1a0;
    localparam logic [11:0] FRB_OFS_BCL    = 12'h1b0;
    localparam logic [11:0] FRB_OFS_BCH    = 12'h1b4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0]  FRB_FSIZE_RST  = 3'h0;
    localparam logic [1:0]  FRB_CMD_RST    = 2'h0;
    localparam logic [31:0] FRB_ZERO_WORD  = 32'h0000_0000;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FRB_PAT_INC  = 3'h0,
        FRB_PAT_DEC  = 3'h1,
        FRB_PAT_ZERO = 3'h2,
        FRB_PAT_ONES = 3'h3,
        FRB_PAT_LFSR = 3'h4
    } frb_pattern_e;

    typedef enum logic [1:0] {
        FRB_CMD_FORMAT = 2'h0,
        FRB_CMD_SPARE  = 2'h1,
        FRB_CMD_WRITE  = 2'h2,
        FRB_CMD_READ   = 2'h3
    } frb_command_e;

    typedef enum logic [1:0] {
        FRB_SPD_NONE = 2'h0,
        FRB_SPD_GEN1 = 2'h1,
        FRB_SPD_GEN2 = 2'h2,
        FRB_SPD_GEN3 = 2'h3
    } frb_speed_e;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [11:0] addr;
        logic        wr;
        logic        rd;
        logic [31:0] wdata;
    } frb_bus_req_s;

    typedef struct packed {
        logic        busy;
        logic        error;
        frb_speed_e  speed;
        logic [15:0] max_file_count;
        logic [31:0] error_cause_vector;
        logic [63:0] core_debug_bus;
    } frb_core_in_s;

    typedef struct packed {
        frb_command_e command_code;
        logic         command_request_pulse;
        logic [15:0]  first_file_name;
        logic [15:0]  file_count;
        logic [2:0]   file_size_select;
        logic [31:0]  creation_timestamp;
        frb_pattern_e pattern_select;
        logic         test_reset;
    } frb_core_out_s;

    typedef struct packed {
        logic [31:0] position;
        logic [15:0] file_id;
        logic [31:0] expected;
        logic [31:0] observed;
    } frb_fail_s;

endpackage : frb_pkg

// ### verilog/frb_regbank.sv
// Purpose: Register bank between the processor and the file storage core.
// Assumes: Register port and core signals synchronous to mclk.
// Notes:   Read data is registered and valid one cycle after the read strobe.
//
// How it works
// - Status bit 2 reads 1 once the checker saw a data mismatch.
// - Status bits 4:3 give link speed: none, first, second, third generation.
// - Capacity register low 16 bits return the core's maximum file count.
// - Error cause register returns the core's full 32-bit error vector.
// - Debug bus low half at one register, upper half at the next.
// - Failing byte position and 16-bit failing file name are readable.
// - Low 32 bits of expected and observed words at the failure readable.
// - Forty-bit byte count read as low word and high byte.
// - File size select resets to 000, the 32 MB setting.
// - Command code 00 asks for a format; core holds busy meanwhile.
// - New file size select is handed to the core to recompute capacity.
// - Command register write loads the code and pulses a request.
// - Status bit 0 mirrors core busy, bit 1 mirrors core error.
// - Three-bit pattern select picks increment, decrement, zeros, ones, LFSR.
`timescale 1ns/1ps
module frb_regbank
    import frb_pkg::*;
#(
    parameter int unsigned BYTE_CNT_W = 40
)
(
    input  wire logic                   mclk,
    input  wire logic                   resetn,
    input  wire frb_pkg::frb_bus_req_s  bus_req,
    output logic [31:0]                 reg_rdata,
    output logic                        reg_rvalid,
    input  wire frb_pkg::frb_core_in_s  core_in,
    output frb_pkg::frb_core_out_s      core_out,
    input  wire logic                   check_mismatch,
    input  wire frb_pkg::frb_fail_s     check_info,
    input  wire logic [BYTE_CNT_W-1:0]  byte_count
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    localparam int unsigned BCH_W = 8;

    if (BYTE_CNT_W <= 32 || BYTE_CNT_W > 32 + BCH_W)
    begin : g_bad_width
        $error("byte count width must be 33 to 40");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        frb_core_out_s        out;
        logic [31:0]          rdata;
        logic                 rvalid;
        logic [BCH_W-1:0]     bch_hold;
    } frb_bank_state_s;

    frb_bank_state_s st_q;
    frb_bank_state_s st_d;

    logic       fail_flag;
    frb_fail_s  fail_held;
    logic       capture_clear;
    logic [31:0] read_word;
    logic [BCH_W-1:0] count_high;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // True for a write strobe at the given offset.
    function automatic logic wr_hit(input frb_bus_req_s req,
                                    input logic [11:0]  ofs);
        wr_hit = req.wr && (req.addr == ofs);
    endfunction : wr_hit

    // Pads a 16-bit field into the low half of a word.
    function automatic logic [31:0] low16(input logic [15:0] v);
        low16 = {16'h0000, v};
    endfunction : low16

    // Builds the status word from core flags, link speed and the fail flag.
    function automatic logic [31:0] status_word(input frb_core_in_s c,
                                                input logic         f);
        status_word = {27'h0000000, c.speed, f, c.error, c.busy};
    endfunction : status_word

    // High byte of the running count, zero-padded above its width.
    always_comb
    begin
        count_high = '0;
        count_high[BYTE_CNT_W-33:0] = byte_count[BYTE_CNT_W-1:32];
    end

    // ------------------------------------------------------------
    // Failure capture
    // ------------------------------------------------------------

    // A new command or a test reset starts a fresh failure record.
    assign capture_clear = wr_hit(bus_req, FRB_OFS_CMD)
                         || st_q.out.test_reset;

    frb_capture u_capture (
        .mclk          (mclk),
        .resetn        (resetn),
        .clear         (capture_clear),
        .mismatch      (check_mismatch),
        .mismatch_info (check_info),
        .failed        (fail_flag),
        .held_info     (fail_held)
    );

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------

    // Selects the word for the read offset; write-only and unmapped read 0.
    always_comb
    begin
        read_word = FRB_ZERO_WORD;
        unique case (bus_req.addr)
            FRB_OFS_STATUS:
            begin
                read_word = status_word(core_in, fail_flag);
            end
            FRB_OFS_CAP:
            begin
                read_word = low16(core_in.max_file_count);
            end
            FRB_OFS_ERR:
            begin
                read_word = core_in.error_cause_vector;
            end
            FRB_OFS_DBGL:
            begin
                read_word = core_in.core_debug_bus[31:0];
            end
            FRB_OFS_DBGH:
            begin
                read_word = core_in.core_debug_bus[63:32];
            end
            FRB_OFS_FPOS:
            begin
                read_word = fail_held.position;
            end
            FRB_OFS_FID:
            begin
                read_word = low16(fail_held.file_id);
            end
            FRB_OFS_EXP:
            begin
                read_word = fail_held.expected;
            end
            FRB_OFS_OBS:
            begin
                read_word = fail_held.observed;
            end
            FRB_OFS_BCL:
            begin
                read_word = byte_count[31:0];
            end
            FRB_OFS_BCH:
            begin
                read_word = {24'h000000, st_q.bch_hold};
            end
            default:
            begin
                read_word = FRB_ZERO_WORD;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    // Register writes, the request pulse and the registered read answer.
    always_comb
    begin
        st_d = st_q;

        // The request lasts exactly one cycle after the command write.
        st_d.out.command_request_pulse = 1'b0;

        // Read answer follows the strobe by one cycle.
        st_d.rvalid = bus_req.rd;
        if (bus_req.rd)
        begin
            st_d.rdata = read_word;
        end

        // The high byte is frozen when the low word is read, so a
        // low-then-high read pair sees one coherent 40-bit count.
        if (bus_req.rd && bus_req.addr == FRB_OFS_BCL)
        begin
            st_d.bch_hold = count_high;
        end

        if (bus_req.wr)
        begin
            unique case (bus_req.addr)
                FRB_OFS_FNAME:
                begin
                    st_d.out.first_file_name = bus_req.wdata[15:0];
                end
                FRB_OFS_FLEN:
                begin
                    st_d.out.file_count = bus_req.wdata[15:0];
                end
                FRB_OFS_FSIZE:
                begin
                    // The core recomputes its file count from this value.
                    st_d.out.file_size_select = bus_req.wdata[2:0];
                end
                FRB_OFS_FTIME:
                begin
                    st_d.out.creation_timestamp = bus_req.wdata;
                end
                FRB_OFS_CMD:
                begin
                    // Code 00 starts a format; the core then holds busy.
                    st_d.out.command_code =
                        frb_command_e'(bus_req.wdata[1:0]);
                    st_d.out.command_request_pulse = 1'b1;
                end
                FRB_OFS_PATT:
                begin
                    st_d.out.pattern_select =
                        frb_pattern_e'(bus_req.wdata[2:0]);
                end
                FRB_OFS_TRST:
                begin
                    st_d.out.test_reset = bus_req.wdata[0];
                end
                default:
                begin
                    // Read-only and unmapped offsets leave every value alone,
                    // so the request pulse still drops after its one cycle.
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    // Reset puts the file size at its 32 MB default.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q                       <= '0;
            st_q.out.file_size_select  <= FRB_FSIZE_RST;
            st_q.out.command_code      <= frb_command_e'(FRB_CMD_RST);
            st_q.out.pattern_select    <= FRB_PAT_INC;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Every output is a flip-flop of the state record.
    assign core_out   = st_q.out;
    assign reg_rdata  = st_q.rdata;
    assign reg_rvalid = st_q.rvalid;

endmodule : frb_regbank
